//--- rtl/desi_top.sv
/*
  Demodulator event, interrupt and status block: 24 clear-on-read event flags,
  per-event interrupt enables, status pin selection and live status bytes.
  Assumes a byte register port driven by the serial-bus slave on ref_clk and
  datapath inputs that may be asynchronous, so they are synchronised here.
*/
`default_nettype none
module desi_top (
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port: address, write data, strobes, read data.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Search configuration from other registers of the device.
  input wire logic go,
  input wire logic [15:0] symbol_rate_setting,
  input wire logic [7:0] fec_wait_units,
  // Datapath indications, asynchronous to ref_clk.
  input wire desi_pkg::desi_lock_s lock_in,
  input wire logic carrier_timing_lock_raw,
  input wire logic fec_lock,
  input wire logic freq_sweep_done,
  input wire logic [5:0] misc_events,
  input wire logic [1:0] afc_events,
  // Pins.
  output logic irq_n,
  output logic status_pin
);
  // Synchroniser stages for all asynchronous inputs.
  localparam int SW = 18;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] prev_q;
  logic [SW-1:0] async_in;
  assign async_in = {lock_in, carrier_timing_lock_raw, fec_lock, freq_sweep_done, misc_events, afc_events};
  // Two flip-flops before any logic reads the inputs.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  // Synchronised view of the inputs.
  desi_pkg::desi_lock_s lk;
  logic ct_raw_s;
  logic fec_s;
  logic sweep_done_s;
  logic sweep_done_rise;
  logic [5:0] misc_s;
  logic [1:0] afc_s;
  assign {lk, ct_raw_s, fec_s, sweep_done_s, misc_s, afc_s} = sync2_q;
  assign sweep_done_rise = sweep_done_s && !prev_q[8];
  // Search engine outputs.
  logic carrier_timing_lock;
  logic full_lock;
  logic [3:0] subrange;
  logic freq_end_p;
  logic rate_end_p;
  logic sweeping;
  logic state_chg_p;
  logic known_mode;
  assign known_mode = symbol_rate_setting[15];
  // Search sequencing and lock handover.
  desi_search desi_search_inst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .go(go),
    .search_mode(known_mode),
    .subrange_sel(symbol_rate_setting[11:0]),
    .carrier_timing_lock_raw(ct_raw_s),
    .fec_lock(fec_s),
    .fec_wait_units(fec_wait_units),
    .freq_sweep_done(sweep_done_rise),
    .carrier_timing_lock(carrier_timing_lock),
    .full_lock(full_lock),
    .subrange(),
    .freq_end_pulse(freq_end_p),
    .rate_end_pulse(rate_end_p),
    .sweeping(sweeping),
    .state_change_pulse(state_chg_p)
  );
  // Previous values of engine levels, for lock/unlock edges.
  logic ct_prev_q;
  logic full_prev_q;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ct_prev_q <= 1'b0;
      full_prev_q <= 1'b0;
    end
    else
    begin
      ct_prev_q <= carrier_timing_lock;
      full_prev_q <= full_lock;
    end
  end
  // Live timing sweep: engine sweeping without timing lock; carrier sweep: engine sweeping with timing lock but no carrier lock.
  logic ts_sweep;
  logic cs_sweep;
  assign ts_sweep = sweeping && !lk.timing;
  assign cs_sweep = sweeping && lk.timing && !lk.carrier;
  // Rising and falling edge of one synchronised bit.
  function automatic logic rise(input logic now, input logic was);
    return now && !was;
  endfunction
  // Event vector, one bit per flag position.
  logic [23:0] ev;
  always_comb
  begin
    ev = 24'h000000;
    ev[desi_pkg::EV_CARRIER_TIMING_LOCK] = carrier_timing_lock && !ct_prev_q;
    ev[desi_pkg::EV_CT_UNLOCK] = !carrier_timing_lock && ct_prev_q;
    ev[desi_pkg::EV_FULL_LOCK] = full_lock && !full_prev_q;
    ev[desi_pkg::EV_UNLOCK] = !full_lock && full_prev_q;
    ev[desi_pkg::EV_TIMING_SYNC_LOCK] = rise(sync2_q[13], prev_q[13]);
    ev[desi_pkg::EV_TS_UNLOCK] = rise(prev_q[13], sync2_q[13]);
    ev[desi_pkg::EV_CS_LOCK] = rise(sync2_q[12], prev_q[12]);
    ev[desi_pkg::EV_CS_UNLOCK] = rise(prev_q[12], sync2_q[12]);
    ev[desi_pkg::EV_FE_GAIN_LOCK] = rise(sync2_q[11], prev_q[11]);
    ev[desi_pkg::EV_TG_LOCK] = rise(sync2_q[14], prev_q[14]);
    ev[desi_pkg::EV_TG_UNLOCK] = rise(prev_q[14], sync2_q[14]);
    ev[desi_pkg::EV_REC_LOCK] = rise(sync2_q[15], prev_q[15]);
    ev[desi_pkg::EV_REC_UNLOCK] = rise(prev_q[15], sync2_q[15]);
    ev[desi_pkg::EV_CALC_DONE] = rise(misc_s[5], prev_q[7]);
    ev[desi_pkg::EV_TIMING_SYNC_MAXIMUM] = rise(misc_s[4], prev_q[6]);
    ev[desi_pkg::EV_CS_MAX] = rise(misc_s[3], prev_q[5]);
    ev[desi_pkg::EV_STATE_CHANGE] = state_chg_p;
    ev[desi_pkg::EV_FREQ_END] = freq_end_p;
    ev[desi_pkg::EV_RATE_END] = rate_end_p;
    ev[desi_pkg::EV_AFC_OK] = rise(afc_s[1], prev_q[1]);
    ev[desi_pkg::EV_AFC_FAIL] = rise(afc_s[0], prev_q[0]);
    ev[desi_pkg::EV_NEXT_STEP] = rise(misc_s[2], prev_q[4]);
    ev[desi_pkg::EV_SAME_STEP] = rise(misc_s[1], prev_q[3]);
    ev[desi_pkg::EV_LOOP_LIMIT] = rise(misc_s[0], prev_q[2]);
  end
  // Register decode strobes.
  logic rd_fh;
  logic rd_fm;
  logic rd_fl;
  assign rd_fh = reg_rd && (reg_addr == desi_pkg::OFF_FLAGS_HIGH);
  assign rd_fm = reg_rd && (reg_addr == desi_pkg::OFF_FLAGS_MID);
  assign rd_fl = reg_rd && (reg_addr == desi_pkg::OFF_FLAGS_LOW);
  // Per-bit clear mask for the flag bytes being read.
  logic [23:0] clr;
  assign clr = {{8{rd_fh}}, {8{rd_fm}}, {8{rd_fl}}};
  // Sticky event flags.
  logic [23:0] flags_q;
  logic [23:0] flags_d;
  assign flags_d = (flags_q & ~clr) | ev;
  // Flags latch independently of the enables, so enables never gate ev here.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flags_q <= desi_pkg::RST_FLAGS;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end
  // Interrupt enables, three bytes; and status pin select.
  logic [23:0] ie_q;
  logic [7:0] sel_q;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ie_q <= {3{desi_pkg::RST_BYTE}};
      sel_q <= desi_pkg::RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == desi_pkg::OFF_IE_HIGH)
      begin
        ie_q[23:16] <= reg_wdata;
      end
      if (reg_addr == desi_pkg::OFF_IE_MID)
      begin
        ie_q[15:8] <= reg_wdata;
      end
      if (reg_addr == desi_pkg::OFF_IE_LOW)
      begin
        ie_q[7:0] <= reg_wdata;
      end
      if (reg_addr == desi_pkg::OFF_STAT_SEL)
      begin
        sel_q <= reg_wdata;
      end
    end
  end
  // Live status bytes.
  logic [7:0] state_high;
  logic [7:0] state_low;
  assign state_high = {lk.quality, lk.recovery, lk.timing_gain, lk.timing, lk.carrier,
                       carrier_timing_lock, full_lock};
  assign state_low = {ts_sweep, cs_sweep, 6'h00};
  // Read data mux; unmapped offsets read as zero.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= desi_pkg::RST_BYTE;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        desi_pkg::OFF_FLAGS_HIGH: reg_rdata <= flags_q[23:16];
        desi_pkg::OFF_FLAGS_MID: reg_rdata <= flags_q[15:8];
        desi_pkg::OFF_FLAGS_LOW: reg_rdata <= flags_q[7:0];
        desi_pkg::OFF_STATE_HIGH: reg_rdata <= state_high;
        desi_pkg::OFF_STATE_LOW: reg_rdata <= state_low;
        desi_pkg::OFF_IE_HIGH: reg_rdata <= ie_q[23:16];
        desi_pkg::OFF_IE_MID: reg_rdata <= ie_q[15:8];
        desi_pkg::OFF_IE_LOW: reg_rdata <= ie_q[7:0];
        desi_pkg::OFF_STAT_SEL: reg_rdata <= sel_q;
        default: reg_rdata <= desi_pkg::RST_BYTE;
      endcase
    end
  end
  // Pin drivers are registered so glitches from the OR trees never reach the board.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_n <= 1'b1;
      status_pin <= 1'b0;
    end
    else
    begin
      irq_n <= ~|(flags_q & ie_q);
      status_pin <= |(sel_q[7:1] & {ts_sweep, cs_sweep, lk.recovery, lk.timing_gain,
                                    lk.timing, lk.carrier, carrier_timing_lock});
    end
  end
endmodule
`default_nettype wire

//--- rtl/desi_pkg.sv
/*
  Shared constants and carrier types for the demodulator event, interrupt and
  status block. Assumes a single 125 MHz clock domain and byte-wide registers
  reached through an eight-bit address/data register port.
*/
`default_nettype none
package desi_pkg;
  // Register offsets.
  localparam logic [7:0] OFF_FLAGS_HIGH = 8'h00;
  localparam logic [7:0] OFF_FLAGS_MID = 8'h01;
  localparam logic [7:0] OFF_FLAGS_LOW = 8'h02;
  localparam logic [7:0] OFF_STATE_HIGH = 8'h04;
  localparam logic [7:0] OFF_STATE_LOW = 8'h05;
  localparam logic [7:0] OFF_IE_HIGH = 8'h1c;
  localparam logic [7:0] OFF_IE_MID = 8'h1d;
  localparam logic [7:0] OFF_IE_LOW = 8'h1e;
  localparam logic [7:0] OFF_STAT_SEL = 8'h20;
  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [23:0] RST_FLAGS = 24'h000000;
  // Event vector bit positions (flags and enables share layout).
  localparam int EV_CARRIER_TIMING_LOCK = 23;
  localparam int EV_CT_UNLOCK = 22;
  localparam int EV_FULL_LOCK = 21;
  localparam int EV_UNLOCK = 20;
  localparam int EV_TIMING_SYNC_LOCK = 19;
  localparam int EV_TS_UNLOCK = 18;
  localparam int EV_CS_LOCK = 17;
  localparam int EV_CS_UNLOCK = 16;
  localparam int EV_FE_GAIN_LOCK = 15;
  localparam int EV_TG_LOCK = 14;
  localparam int EV_TG_UNLOCK = 13;
  localparam int EV_REC_LOCK = 12;
  localparam int EV_REC_UNLOCK = 11;
  localparam int EV_CALC_DONE = 10;
  localparam int EV_TIMING_SYNC_MAXIMUM = 9;
  localparam int EV_CS_MAX = 8;
  localparam int EV_STATE_CHANGE = 7;
  localparam int EV_FREQ_END = 6;
  localparam int EV_RATE_END = 5;
  localparam int EV_AFC_OK = 4;
  localparam int EV_AFC_FAIL = 3;
  localparam int EV_NEXT_STEP = 2;
  localparam int EV_SAME_STEP = 1;
  localparam int EV_LOOP_LIMIT = 0;
  // Number of symbol-rate sub-ranges.
  localparam int NUM_SUBRANGES = 12;
  // One unit of the lock-wait interval, in ns, and its cycle count at 8 ns.
  localparam int LOCK_UNIT_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOCK_UNIT_CYC = LOCK_UNIT_NS / CLK_PERIOD_NS;
  // Live lock indications from the demodulator datapath.
  typedef struct packed {
    logic [1:0] quality;
    logic recovery;
    logic timing_gain;
    logic timing;
    logic carrier;
    logic frontend_gain;
  } desi_lock_s;
  // Search engine control state.
  typedef enum logic [1:0] {SR_IDLE, SR_SWEEP, SR_WAIT_FEC, SR_LOCKED} desi_search_e;
endpackage
`default_nettype wire

//--- rtl/desi_search.sv
/*
  Search sequencer: frequency sweep, symbol-rate sub-range stepping and the
  carrier-timing lock to full lock handover. Assumes one clock domain and a
  datapath that reports lock levels and a frequency-range-end strobe.
*/
`default_nettype none
module desi_search (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic search_mode,
  input wire logic [11:0] subrange_sel,
  input wire logic carrier_timing_lock_raw,
  input wire logic fec_lock,
  input wire logic [7:0] fec_wait_units,
  input wire logic freq_sweep_done,
  output logic carrier_timing_lock,
  output logic full_lock,
  output logic [3:0] subrange,
  output logic freq_end_pulse,
  output logic rate_end_pulse,
  output logic sweeping,
  output logic state_change_pulse
);
  // Current sequencer state.
  desi_pkg::desi_search_e state_q;
  // Counts cycles inside one wait unit.
  logic [15:0] unit_cnt_q;
  // Counts wait units spent waiting for the decoder.
  logic [7:0] wait_cnt_q;
  // Highest selected sub-range strictly below a given index.
  function automatic logic [4:0] next_below(input logic [11:0] sel, input logic [4:0] from);
    logic [4:0] r;
    r = 5'h1f;
    for (int i = 0; i < desi_pkg::NUM_SUBRANGES; i++)
    begin
      if (sel[i] && (5'(i) < from))
      begin
        r = 5'(i);
      end
    end
    return r;
  endfunction
  logic [4:0] top_sel;
  logic [4:0] lower_sel;
  assign top_sel = next_below(subrange_sel, 5'h10);
  assign lower_sel = next_below(subrange_sel, {1'b0, subrange});
  // Sequencer: sweep, wait for decoder, hold lock.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= desi_pkg::SR_IDLE;
      subrange <= 4'h0;
      freq_end_pulse <= 1'b0;
      rate_end_pulse <= 1'b0;
      state_change_pulse <= 1'b0;
      unit_cnt_q <= 16'h0000;
      wait_cnt_q <= 8'h00;
    end
    else
    begin
      freq_end_pulse <= 1'b0;
      rate_end_pulse <= 1'b0;
      state_change_pulse <= 1'b0;
      unique case (state_q)
        desi_pkg::SR_IDLE:
        begin
          if (go)
          begin
            state_q <= desi_pkg::SR_SWEEP;
            state_change_pulse <= 1'b1;
            subrange <= (top_sel[4]) ? 4'h0 : top_sel[3:0];
          end
        end
        desi_pkg::SR_SWEEP:
        begin
          if (carrier_timing_lock_raw)
          begin
            state_q <= desi_pkg::SR_WAIT_FEC;
            state_change_pulse <= 1'b1;
            unit_cnt_q <= 16'h0000;
            wait_cnt_q <= 8'h00;
          end
          else if (freq_sweep_done)
          begin
            freq_end_pulse <= 1'b1;
            if (search_mode)
            begin
              if (lower_sel[4])
              begin
                rate_end_pulse <= 1'b1;
                subrange <= (top_sel[4]) ? 4'h0 : top_sel[3:0];
              end
              else
              begin
                subrange <= lower_sel[3:0];
              end
            end
          end
        end
        desi_pkg::SR_WAIT_FEC:
        begin
          if (fec_lock)
          begin
            state_q <= desi_pkg::SR_LOCKED;
            state_change_pulse <= 1'b1;
          end
          else if (!carrier_timing_lock_raw || wait_cnt_q >= fec_wait_units)
          begin
            state_q <= desi_pkg::SR_SWEEP;
            state_change_pulse <= 1'b1;
          end
          else if (unit_cnt_q == 16'(desi_pkg::LOCK_UNIT_CYC - 1))
          begin
            unit_cnt_q <= 16'h0000;
            wait_cnt_q <= wait_cnt_q + 8'h01;
          end
          else
          begin
            unit_cnt_q <= unit_cnt_q + 16'h0001;
          end
        end
        desi_pkg::SR_LOCKED:
        begin
          // Losing either lock sends the engine back to searching.
          if (!carrier_timing_lock_raw || !fec_lock)
          begin
            state_q <= desi_pkg::SR_SWEEP;
            state_change_pulse <= 1'b1;
          end
        end
      endcase
    end
  end
  // Lock and sweep levels follow the state directly.
  assign carrier_timing_lock = (state_q == desi_pkg::SR_WAIT_FEC) || (state_q == desi_pkg::SR_LOCKED);
  assign full_lock = (state_q == desi_pkg::SR_LOCKED);
  assign sweeping = (state_q == desi_pkg::SR_SWEEP);
endmodule
`default_nettype wire

//--- sim/desi_top_asserts.sv
/*
  Port-level checker for desi_top: register port, interrupt and status pins.
  Assumes a bind to desi_top; enable and select bytes are shadowed from writes.
*/
`default_nettype none
module desi_top_asserts (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire desi_pkg::desi_lock_s lock_in,
  input wire logic [5:0] misc_events,
  input wire logic [1:0] afc_events,
  input wire logic irq_n,
  input wire logic status_pin
);
  // Shadow enable and select bytes, rebuilt from host writes.
  logic [23:0] ie_q;
  logic [7:0] sel_q;
  // Last event sources and how long they stood still, saturating at 7.
  logic [14:0] src_q;
  logic [2:0] quiet_q;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // Follow host writes so the pins can be judged against the enables.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ie_q <= 24'h000000;
      sel_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        desi_pkg::OFF_IE_HIGH: ie_q[23:16] <= reg_wdata;
        desi_pkg::OFF_IE_MID: ie_q[15:8] <= reg_wdata;
        desi_pkg::OFF_IE_LOW: ie_q[7:0] <= reg_wdata;
        desi_pkg::OFF_STAT_SEL: sel_q <= reg_wdata;
        default: ;
      endcase
    end
  end
  // Seven still cycles cover the synchroniser and the flag stage, so no set races a read.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      src_q <= 15'h0000;
      quiet_q <= 3'h0;
    end
    else
    begin
      src_q <= {lock_in, misc_events, afc_events};
      if ({lock_in, misc_events, afc_events} != src_q)
        quiet_q <= 3'h0;
      else if (quiet_q != 3'h7)
        quiet_q <= quiet_q + 3'h1;
    end
  end
  a_ie_readback: assert property (
    (reg_wr && reg_addr == desi_pkg::OFF_IE_MID) ##2 (reg_rd && reg_addr == desi_pkg::OFF_IE_MID)
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("enable byte read back wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h03 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_state_low_rsvd: assert property (
    reg_rd && reg_addr == desi_pkg::OFF_STATE_LOW |=> reg_rdata[5:0] == 6'h00)
    else $error("reserved status bits set");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_mid_cleared: assert property (
    (reg_rd && reg_addr == desi_pkg::OFF_FLAGS_MID && quiet_q == 3'h7) ##2
    (reg_rd && reg_addr == desi_pkg::OFF_FLAGS_MID) |=> reg_rdata == 8'h00)
    else $error("flag byte not cleared by read");
  a_state_high: assert property (
    reg_rd && reg_addr == desi_pkg::OFF_STATE_HIGH && quiet_q == 3'h7
    |=> reg_rdata[7:2] == lock_in[6:1])
    else $error("live state byte wrong");
  a_irq_masked: assert property ((ie_q == 24'h000000) [*3] |-> irq_n)
    else $error("interrupt with all enables low");
  a_pin_off: assert property ((sel_q[7:1] == 7'h00) [*4] |-> !status_pin)
    else $error("status pin high with nothing selected");
  a_pin_timing: assert property (
    (quiet_q == 3'h7 && sel_q[7:1] == 7'h04) [*4] |-> status_pin == lock_in.timing)
    else $error("status pin not following timing lock");
endmodule
`default_nettype wire

//--- sim/desi_host.sv
/*
  Host processor model: byte writes and reads on the register port.
  Assumes the block takes strobes on the rising edge of ref_clk.
*/
`default_nettype none
module desi_host (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Port idle from time zero, so nothing is taken during reset.
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // A write is held across one rising edge, then released; one idle edge follows.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = (a == desi_pkg::OFF_STAT_SEL) ? {d[7:1], 1'b0} : d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  // Read data is registered, so it is taken half a cycle after the taking edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- sim/desi_top_test.sv
/*
  Self-checking bench for desi_top with the host model on the register port.
  Assumes the checker is bound in below; inputs change on falling edges.
*/
`default_nettype none
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module desi_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk;
  logic rstn;
  logic go;
  logic [15:0] symbol_rate_setting;
  logic [7:0] fec_wait_units;
  desi_pkg::desi_lock_s lock_in;
  logic carrier_timing_lock_raw;
  logic fec_lock;
  logic freq_sweep_done;
  logic [5:0] misc_events;
  logic [1:0] afc_events;
  wire logic [7:0] reg_addr;
  wire logic [7:0] reg_wdata;
  wire logic reg_wr;
  wire logic reg_rd;
  wire logic [7:0] reg_rdata;
  wire logic irq_n;
  wire logic status_pin;
  int fail_count;
  int total_checks;
  desi_top desi_top_inst (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .go(go),
    .symbol_rate_setting(symbol_rate_setting), .fec_wait_units(fec_wait_units),
    .lock_in(lock_in), .carrier_timing_lock_raw(carrier_timing_lock_raw), .fec_lock(fec_lock),
    .freq_sweep_done(freq_sweep_done), .misc_events(misc_events), .afc_events(afc_events),
    .irq_n(irq_n), .status_pin(status_pin));
  desi_host desi_host_inst (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // Wait whole cycles, landing on a falling edge.
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Read a register and compare the bits under the mask.
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    desi_host_inst.rd(a, d);
    `CHK(d & m, e)
  endtask
  // Every register and an unmapped place read zero after reset.
  task automatic t_reset();
    logic [7:0] adr [10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h1c, 8'h1d, 8'h1e, 8'h20, 8'h03};
    foreach (adr[i]) rdc(adr[i], 8'h00, 8'hff);
  endtask
  // Enable and select bytes read back; a write to a status byte is ignored.
  task automatic t_regs();
    logic [7:0] adr [4] = '{8'h1c, 8'h1d, 8'h1e, 8'h20};
    logic [7:0] val [4] = '{8'ha5, 8'h5a, 8'hc3, 8'hfe};
    foreach (adr[i])
    begin
      desi_host_inst.wr(adr[i], val[i]);
      rdc(adr[i], val[i], 8'hff);
      desi_host_inst.wr(adr[i], 8'h00);
    end
    desi_host_inst.wr(8'h04, 8'hff);
    rdc(8'h04, 8'h00, 8'hff);
  endtask
  // Each misc and AFC event source latches its own flag with enables low, and a read clears it.
  task automatic t_events();
    logic [7:0] adr [8] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h01, 8'h01, 8'h01};
    logic [7:0] bits [8] = '{8'h08, 8'h10, 8'h01, 8'h02, 8'h04, 8'h01, 8'h02, 8'h04};
    for (int k = 0; k < 8; k++)
    begin
      {misc_events, afc_events} = 8'h01 << k;
      cyc(8);
      {misc_events, afc_events} = 8'h00;
      cyc(8);
      rdc(adr[k], bits[k], 8'hff);
      rdc(adr[k], 8'h00, 8'hff);
      `CHK(irq_n, 1'b1)
    end
  endtask
  // Only an enabled flag pulls the interrupt low; the read releases it.
  task automatic t_irq();
    desi_host_inst.wr(8'h1c, 8'hff);
    desi_host_inst.wr(8'h1d, 8'hfb);
    desi_host_inst.wr(8'h1e, 8'hff);
    misc_events = 6'h20;
    cyc(8);
    `CHK(irq_n, 1'b1)
    desi_host_inst.wr(8'h1d, 8'hff);
    cyc(2);
    `CHK(irq_n, 1'b0)
    misc_events = 6'h00;
    rdc(8'h01, 8'h04, 8'hff);
    cyc(2);
    `CHK(irq_n, 1'b1)
    desi_host_inst.wr(8'h1c, 8'h00);
    desi_host_inst.wr(8'h1d, 8'h00);
    desi_host_inst.wr(8'h1e, 8'h00);
  endtask
  // Timing lock shows in flags, live state and, when selected, on the status pin.
  task automatic t_status();
    logic [7:0] sel [5] = '{8'h08, 8'h04, 8'h0c, 8'h80, 8'hfe};
    logic pin [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    lock_in.timing = 1'b1;
    lock_in.quality = 2'b10;
    cyc(8);
    rdc(8'h00, 8'h08, 8'hff);
    rdc(8'h04, 8'h88, 8'hfc);
    rdc(8'h05, 8'h00, 8'hff);
    foreach (sel[i])
    begin
      desi_host_inst.wr(8'h20, sel[i]);
      cyc(6);
      `CHK(status_pin, pin[i])
    end
    desi_host_inst.wr(8'h20, 8'h00);
    lock_in = '0;
    cyc(8);
    rdc(8'h00, 8'h04, 8'hff);
  endtask
  // Known rate: a range end raises the frequency end flag but not the rate end flag.
  task automatic t_search();
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(4);
    freq_sweep_done = 1'b1;
    cyc(8);
    freq_sweep_done = 1'b0;
    rdc(8'h02, 8'h40, 8'h60);
  endtask
  // Unknown rate with sub-ranges 2 and 0: ending the lowest one also ends the rate
  // range and the sweep returns to the highest, so every other range end is also a rate end.
  task automatic t_subrange();
    logic [7:0] exp [3] = '{8'h60, 8'h40, 8'h60};
    symbol_rate_setting = 16'h8005;
    foreach (exp[i])
    begin
      freq_sweep_done = 1'b1;
      cyc(8);
      freq_sweep_done = 1'b0;
      cyc(4);
      rdc(8'h02, exp[i], 8'h60);
    end
  endtask
  // Print the verdict and stop.
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // The scenarios take a few hundred cycles; this limit is more than fifty times that.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    fail_count = 0;
    total_checks = 0;
    rstn = 1'b0;
    go = 1'b0;
    symbol_rate_setting = 16'h0000;
    fec_wait_units = 8'h01;
    lock_in = '0;
    carrier_timing_lock_raw = 1'b0;
    fec_lock = 1'b0;
    freq_sweep_done = 1'b0;
    misc_events = 6'h00;
    afc_events = 2'h0;
    cyc(5);
    rstn = 1'b1;
    t_reset();
    t_regs();
    t_events();
    t_irq();
    t_status();
    t_search();
    t_subrange();
    end_of_test();
  end
endmodule
bind desi_top desi_top_asserts desi_top_asserts_inst (.ref_clk(ref_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .lock_in(lock_in), .misc_events(misc_events),
  .afc_events(afc_events), .irq_n(irq_n), .status_pin(status_pin));
`default_nettype wire
